// >>> hdl/rtc_trim_pkg.sv
// package: constants and carrier types for the rtc rate trim and halt monitor
package rtc_trim_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned OSC_HZ            = 32768;
  localparam int unsigned TRIM_PERIOD_S     = 20;
  localparam int unsigned SAMPLE_WINDOW_US  = 7800;
  localparam int unsigned SAMPLE_PERIOD_S   = 1;
  // least time: round up
  localparam int unsigned SAMPLE_WINDOW_CYC = (SAMPLE_WINDOW_US * OSC_HZ + 999_999) / 1_000_000;
  localparam int unsigned OSC_PER_SEC       = OSC_HZ * SAMPLE_PERIOD_S;
  // one spare bit: a slowed second counts past 32767 ticks
  localparam int unsigned SEC_CNT_W         = 16;
  localparam int unsigned TRIM_CNT_W        = 5;
  localparam logic [4:0]  TRIM_SECONDS_LAST = 5'(TRIM_PERIOD_S - 1);
  localparam logic [15:0] OSC_TICKS_LAST    = 16'(OSC_PER_SEC - 1);
  localparam logic [15:0] SAMPLE_TICKS      = 16'(SAMPLE_WINDOW_CYC);
  localparam int unsigned HALT_TIMEOUT      = 4;
  // halt detector: clk_sys cycles without an oscillator edge before halt
  localparam int unsigned HALT_CYC_DEFAULT  = (CLK_HZ / OSC_HZ) * HALT_TIMEOUT;

  // trim code
  localparam int unsigned TRIM_W            = 7;
  localparam logic [6:0]  TRIM_ZERO         = 7'h00;
  localparam logic [6:0]  TRIM_PLUS1        = 7'h01;
  localparam logic [6:0]  TRIM_MINUS64      = 7'h40;
  localparam logic [6:0]  TRIM_MINUS63      = 7'h41;
  localparam logic [7:0]  TRIM_SLOW_BASE    = 8'h01;
  localparam logic [7:0]  TRIM_FAST_BASE    = 8'h80;
  localparam logic [7:0]  TRIM_REG_RESET    = 8'h00;

  // serial register port: one write strobe, live read value
  typedef struct packed {
    logic       wr;
    logic [7:0] data;
  } reg_write_t;

  // configuration bits that a recorded halt clears
  typedef struct packed {
    logic       weekly_alarm_enable;
    logic       daily_alarm_enable;
    logic       hour_format_24;
    logic       clock_out_enable_a;
    logic       clock_out_enable_b;
    logic       test_mode;
    logic       periodic_select_2;
    logic       periodic_select_1;
    logic       periodic_select_0;
    logic       threshold_select;
    logic       scratch_bit;
    logic       periodic_irq_flag;
    logic       weekly_alarm_flag;
    logic       daily_alarm_flag;
  } cfg_bits_t;
  localparam int unsigned CFG_W = $bits(cfg_bits_t);

  typedef struct packed {
    logic osc_halt_flag;
    logic low_supply_flag;
  } status_t;

  typedef enum logic [2:0] {
    MON_IDLE   = 3'b001,
    MON_SAMPLE = 3'b010,
    MON_HOLD   = 3'b100
  } mon_state_t;
endpackage : rtc_trim_pkg

// >>> hdl/rtc_sync2.sv
// two-flop synchroniser for a group of pin levels
module rtc_sync2 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         reset_in,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule : rtc_sync2

// >>> hdl/rtc_trim_counter.sv
// one-second divider with 20 second trim interval and supply sample window
module rtc_trim_counter
  import rtc_trim_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              reset_in,
  // oscillator tick and trim
  input  wire logic              osc_tick_in,
  input  wire logic [TRIM_W-1:0] trim_code_in,
  // timing outputs
  output logic                   second_pulse_out,
  output logic                   sample_window_out
);
  import rtc_trim_pkg::*;

  logic [SEC_CNT_W-1:0]  tick_reg;
  logic [SEC_CNT_W-1:0]  tick_next;
  logic [TRIM_CNT_W-1:0] sec_reg;
  logic [TRIM_CNT_W-1:0] sec_next;
  logic [TRIM_W-1:0]     trim_live_reg;
  logic [TRIM_W-1:0]     trim_live_next;
  logic [SEC_CNT_W-1:0]  last_tick;
  logic [7:0]            steps;
  logic                  slow;
  logic                  no_trim;
  logic                  sec_done;

  always_comb begin
    no_trim = (trim_live_reg == TRIM_ZERO) || (trim_live_reg == TRIM_PLUS1) ||
              (trim_live_reg == TRIM_MINUS64) || (trim_live_reg == TRIM_MINUS63);
    slow  = ~trim_live_reg[TRIM_W-1];
    // slow: distance from 01h; fast: distance from 80h
    steps = slow ? ({1'b0, trim_live_reg} - TRIM_SLOW_BASE)
                 : (TRIM_FAST_BASE - {1'b0, trim_live_reg});
    last_tick = OSC_TICKS_LAST;
    // trim only the first second of each interval, two ticks per step:
    // a single tick in 20 s would be only half of the 3.05 ppm step
    if (!no_trim && sec_reg == '0) begin
      last_tick = slow ? OSC_TICKS_LAST + SEC_CNT_W'({steps, 1'b0})
                       : OSC_TICKS_LAST - SEC_CNT_W'({steps, 1'b0});
    end
    sec_done  = osc_tick_in && (tick_reg == last_tick);
    tick_next = tick_reg;
    sec_next  = sec_reg;
    trim_live_next = trim_live_reg;
    if (osc_tick_in) begin
      tick_next = sec_done ? '0 : tick_reg + 1'b1;
    end
    if (sec_done) begin
      if (sec_reg == TRIM_SECONDS_LAST) begin
        sec_next       = '0;
        trim_live_next = trim_code_in;
      end else begin
        sec_next = sec_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      tick_reg      <= '0;
      sec_reg       <= '0;
      trim_live_reg <= '0;
    end else begin
      tick_reg      <= tick_next;
      sec_reg       <= sec_next;
      trim_live_reg <= trim_live_next;
    end
  end

  // sub-clock output is untouched; only this chain is trimmed
  assign second_pulse_out  = sec_done;
  assign sample_window_out = (tick_reg < SAMPLE_TICKS);
endmodule : rtc_trim_counter

// >>> hdl/rtc_trim_and_halt_monitor.sv
// rate trim, oscillator halt and low supply flags of a serial rtc
module rtc_trim_and_halt_monitor
  import rtc_trim_pkg::*;
#(
  parameter int unsigned HALT_CYC = HALT_CYC_DEFAULT
) (
  // clock and reset
  input  wire logic                    clk_sys_in,
  input  wire logic                    reset_in,
  // pins and analog comparator levels
  input  wire logic                    osc_clk_level_in,
  input  wire logic                    chip_enable_in,
  input  wire logic                    below_2v1_in,
  input  wire logic                    below_1v6_in,
  // register port from serial engine
  input  wire rtc_trim_pkg::reg_write_t trim_write_in,
  input  wire rtc_trim_pkg::cfg_bits_t  cfg_write_data_in,
  input  wire logic                    cfg_write_in,
  input  wire rtc_trim_pkg::status_t    status_write_data_in,
  input  wire logic                    status_write_in,
  // register read values
  output logic [7:0]                   rate_trim_register_out,
  output rtc_trim_pkg::cfg_bits_t      cfg_bits_out,
  output rtc_trim_pkg::status_t        status_out,
  output logic [1:0]                   condition_out,
  // timing
  output logic                         sub_clock_output_out,
  output logic                         second_pulse_out,
  output logic                         sample_active_out
);
  import rtc_trim_pkg::*;

  localparam logic [1:0] COND_NORMAL = 2'h0;
  localparam logic [1:0] COND_SUPPLY = 2'h1;
  localparam logic [1:0] COND_HALT   = 2'h2;
  localparam int unsigned HALT_W     = $clog2(HALT_CYC + 1);
  localparam logic [HALT_W-1:0] HALT_LAST = HALT_W'(HALT_CYC);

  logic [3:0] pins_sync;
  logic       osc_s;
  logic       ce_s;
  logic       b21_s;
  logic       b16_s;

  rtc_sync2 #(.W(4)) i_rtc_sync2 (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .async_in   ({osc_clk_level_in, chip_enable_in, below_2v1_in, below_1v6_in}),
    .sync_out   (pins_sync)
  );
  assign {osc_s, ce_s, b21_s, b16_s} = pins_sync;

  // oscillator edge detect on the synchronised level
  logic osc_d_reg;
  logic osc_d_next;
  logic osc_tick;
  assign osc_tick = osc_s & ~osc_d_reg;

  // halt watchdog
  logic [HALT_W-1:0] halt_cnt_reg;
  logic [HALT_W-1:0] halt_cnt_next;
  logic              halt_event;

  // power-on marker: first cycle out of reset counts as power-up
  logic por_done_reg;
  logic por_done_next;

  logic [7:0]  trim_reg;
  logic [7:0]  trim_next;
  cfg_bits_t   cfg_reg;
  cfg_bits_t   cfg_next;
  status_t     st_reg;
  status_t     st_next;
  mon_state_t  mon_reg;
  mon_state_t  mon_next;
  logic        sub_clk_reg;
  logic        sub_clk_next;
  logic        sec_pulse;
  logic        sample_win;
  logic        below_sel;
  logic        set_halt;
  logic        set_low;

  rtc_trim_counter i_rtc_trim_counter (
    .clk_sys_in        (clk_sys_in),
    .reset_in          (reset_in),
    .osc_tick_in       (osc_tick),
    .trim_code_in      (trim_reg[TRIM_W-1:0]),
    .second_pulse_out  (sec_pulse),
    .sample_window_out (sample_win)
  );

  // halt detection: stalls counted only while chip enable is low
  always_comb begin
    osc_d_next    = osc_s;
    halt_cnt_next = halt_cnt_reg;
    halt_event    = 1'b0;
    if (osc_tick || ce_s) begin
      halt_cnt_next = '0;
    end else if (halt_cnt_reg != HALT_LAST) begin
      halt_cnt_next = halt_cnt_reg + 1'b1;
    end else begin
      halt_event = 1'b1;
    end
    por_done_next = 1'b1;
  end

  // supply monitor sequencing
  always_comb begin
    mon_next = mon_reg;
    case (mon_reg)
      MON_IDLE: begin
        if (sec_pulse && !st_reg.low_supply_flag) begin
          mon_next = MON_SAMPLE;
        end
      end
      MON_SAMPLE: begin
        if (st_reg.low_supply_flag) begin
          mon_next = MON_HOLD;
        end else if (!sample_win) begin
          mon_next = MON_IDLE;
        end
      end
      MON_HOLD: begin
        if (!st_reg.low_supply_flag) begin
          mon_next = MON_IDLE;
        end
      end
      default: mon_next = MON_IDLE;
    endcase
  end

  // threshold choice; a level from the comparator is only recorded in the flag
  assign below_sel = cfg_reg.threshold_select ? b16_s : b21_s;
  assign set_low   = (mon_reg == MON_SAMPLE) && sample_win && below_sel;
  assign set_halt  = halt_event || !por_done_reg;

  // registers and flags
  always_comb begin
    trim_next    = trim_reg;
    cfg_next     = cfg_reg;
    st_next      = st_reg;
    sub_clk_next = osc_s;
    if (trim_write_in.wr) begin
      trim_next = {1'b0, trim_write_in.data[TRIM_W-1:0]};
    end
    if (cfg_write_in) begin
      cfg_next = cfg_write_data_in;
    end
    // software can only clear flags; set beats clear in the same cycle
    if (status_write_in) begin
      if (!status_write_data_in.osc_halt_flag) begin
        st_next.osc_halt_flag = 1'b0;
      end
      if (!status_write_data_in.low_supply_flag) begin
        st_next.low_supply_flag = 1'b0;
      end
    end
    if (set_low) begin
      st_next.low_supply_flag = 1'b1;
    end
    if (set_halt) begin
      st_next.osc_halt_flag   = 1'b1;
      st_next.low_supply_flag = 1'b0;
      trim_next               = '0;
      cfg_next                = '0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      osc_d_reg    <= 1'b0;
      halt_cnt_reg <= '0;
      por_done_reg <= 1'b0;
      trim_reg     <= TRIM_REG_RESET;
      cfg_reg      <= '0;
      st_reg       <= '0;
      mon_reg      <= MON_IDLE;
      sub_clk_reg  <= 1'b0;
    end else begin
      osc_d_reg    <= osc_d_next;
      halt_cnt_reg <= halt_cnt_next;
      por_done_reg <= por_done_next;
      trim_reg     <= trim_next;
      cfg_reg      <= cfg_next;
      st_reg       <= st_next;
      mon_reg      <= mon_next;
      sub_clk_reg  <= sub_clk_next;
    end
  end

  // flag decode; low-supply ignored while halted
  always_comb begin
    if (st_reg.osc_halt_flag) begin
      condition_out = COND_HALT;
    end else if (st_reg.low_supply_flag) begin
      condition_out = COND_SUPPLY;
    end else begin
      condition_out = COND_NORMAL;
    end
  end

  assign rate_trim_register_out = trim_reg;
  assign cfg_bits_out           = cfg_reg;
  assign status_out             = st_reg;
  assign sub_clock_output_out   = sub_clk_reg;
  assign second_pulse_out       = sec_pulse;
  assign sample_active_out      = (mon_reg == MON_SAMPLE);
endmodule : rtc_trim_and_halt_monitor

// >>> verif/rtc_trim_checker.sv
// checker: port relations of the rtc rate trim and halt monitor
module rtc_trim_checker
  import rtc_trim_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys_in,
  input wire logic       reset_in,
  // inputs
  input wire logic       osc_clk_level_in,
  input wire logic       chip_enable_in,
  input wire reg_write_t trim_write_in,
  input wire cfg_bits_t  cfg_write_data_in,
  input wire logic       cfg_write_in,
  input wire status_t    status_write_data_in,
  input wire logic       status_write_in,
  // outputs
  input wire logic [7:0] rate_trim_register_out,
  input wire cfg_bits_t  cfg_bits_out,
  input wire status_t    status_out,
  input wire logic [1:0] condition_out,
  input wire logic       sub_clock_output_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  logic halt_set;
  assign halt_set = status_out.osc_halt_flag;
  a_trim_write_lands: assert property (trim_write_in.wr |=> rate_trim_register_out == {1'b0, $past(trim_write_in.data[6:0])} || $rose(halt_set))
    else $error("trim register did not take the write");
  a_trim_msb_zero: assert property (rate_trim_register_out[7] == 1'b0)
    else $error("trim register bit 7 not zero");
  a_halt_clears_cfg: assert property ($rose(halt_set) |-> rate_trim_register_out == 8'h00 && cfg_bits_out == '0)
    else $error("halt did not clear configuration");
  a_halt_drops_low: assert property ($rose(halt_set) |-> !status_out.low_supply_flag)
    else $error("low supply flag set together with halt");
  a_halt_is_sticky: assert property (halt_set && !(status_write_in && !status_write_data_in.osc_halt_flag) |=> halt_set)
    else $error("halt flag fell without a clear");
  a_low_is_sticky: assert property (status_out.low_supply_flag && !(status_write_in && !status_write_data_in.low_supply_flag) |=> status_out.low_supply_flag || halt_set)
    else $error("low supply flag fell without a clear");
  a_ce_high_no_halt: assert property ((chip_enable_in && !reset_in) [*5] |=> !$rose(halt_set))
    else $error("halt recorded while chip enable high");
  a_cond_decode: assert property (condition_out == (halt_set ? 2'd2 : (status_out.low_supply_flag ? 2'd1 : 2'd0)))
    else $error("condition code does not match flags");
  a_cfg_write_lands: assert property (cfg_write_in |=> cfg_bits_out == $past(cfg_write_data_in) || $rose(halt_set))
    else $error("configuration did not take the write");
  a_subclk_follows: assert property ($rose(sub_clock_output_out) |-> $past(osc_clk_level_in, 2) || $past(osc_clk_level_in, 3) || $past(osc_clk_level_in, 4))
    else $error("sub clock rose without oscillator");
  c_halt_event: cover property ($rose(halt_set));
  c_trim_write: cover property (trim_write_in.wr);
  c_flag_clear: cover property ($fell(halt_set));
endmodule : rtc_trim_checker

bind rtc_trim_and_halt_monitor rtc_trim_checker i_rtc_trim_checker (.*);

// >>> verif/rtc_osc_model.sv
// oscillator at the far side: runs or stops on command
module rtc_osc_model #(
  parameter int unsigned HALF = 8
) (
  input  wire logic clk_sys_in,
  input  wire logic run_in,
  output logic      osc_clk_level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned cnt = 0;
  initial osc_clk_level_out = 1'b0;
  // a stopped crystal holds its level, so the design sees no edge
  always @(posedge clk_sys_in) begin
    if (run_in) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) osc_clk_level_out <= ~osc_clk_level_out;
    end
  end
endmodule : rtc_osc_model

// >>> verif/rtc_trim_and_halt_monitor_test.sv
// testbench: register writes, power-up and halt handling
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module rtc_trim_and_halt_monitor_test;
  import rtc_trim_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 0, reset_in = 1, run = 1, ce = 1, cfg_wr = 0, st_wr = 0;
  logic osc, subclk, sec, samp, prev;
  logic b21 = 0, b16 = 0, sub_prev = 0;
  reg_write_t tw = '0;
  cfg_bits_t  cfg_d = '0, cfg_q;
  status_t    st_d = '0, st_q;
  logic [7:0] trim_q;
  logic [1:0] cond;
  int miscompares = 0, n_tests = 0, k, toggles, rises = 0;
  logic [7:0] codes [10] = '{8'h00, 8'h01, 8'h40, 8'h41, 8'h02, 8'h3F, 8'h7F, 8'h42, 8'h09, 8'hD7};
  always #25 clk_sys_in = ~clk_sys_in;
  // fastest crystal the synchroniser can follow, so a whole second fits in the run
  rtc_osc_model #(.HALF(1)) i_rtc_osc_model (.clk_sys_in(clk_sys_in), .run_in(run),
    .osc_clk_level_out(osc));
  // oscillator rises seen since reset, through the untrimmed sub-clock
  always @(negedge clk_sys_in) begin
    sub_prev <= subclk;
    if (reset_in) rises <= 0;
    else if (subclk && !sub_prev) rises <= rises + 1;
  end
  rtc_trim_and_halt_monitor #(.HALT_CYC(40)) i_rtc_trim_and_halt_monitor (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .osc_clk_level_in(osc),
    .chip_enable_in(ce), .below_2v1_in(b21), .below_1v6_in(b16),
    .trim_write_in(tw), .cfg_write_data_in(cfg_d), .cfg_write_in(cfg_wr),
    .status_write_data_in(st_d), .status_write_in(st_wr),
    .rate_trim_register_out(trim_q), .cfg_bits_out(cfg_q), .status_out(st_q),
    .condition_out(cond), .sub_clock_output_out(subclk), .second_pulse_out(sec),
    .sample_active_out(samp));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : cyc
  task automatic wr_trim(input logic [7:0] d);
    tw = '{wr: 1'b1, data: d}; cyc(1); tw.wr = 1'b0; cyc(1);
  endtask : wr_trim
  task automatic wr_cfg(input cfg_bits_t d);
    cfg_d = d; cfg_wr = 1'b1; cyc(1); cfg_wr = 1'b0; cyc(1);
  endtask : wr_cfg
  task automatic wr_status(input status_t d);
    st_d = d; st_wr = 1'b1; cyc(1); st_wr = 1'b0; cyc(1);
  endtask : wr_status
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  initial begin
    cyc(3);
    reset_in = 1'b0;
    cyc(2);
    `CHK(st_q, 2'b10)
    `CHK(cond, 2'd2)
    `CHK(trim_q, 8'h00)
    wr_status('0);
    `CHK(st_q, 2'b00)
    `CHK(cond, 2'd0)
    // every reserved, slowing and speeding code stores with bit 7 cleared
    for (k = 0; k < 10; k++) begin
      wr_trim(codes[k]);
      `CHK(trim_q, {1'b0, codes[k][6:0]})
    end
    wr_cfg('1);
    `CHK(cfg_q, 14'h3FFF)
    toggles = 0;
    for (k = 0; k < 64; k++) begin
      prev = subclk;
      cyc(1);
      if (subclk !== prev) toggles++;
    end
    `CHK(toggles > 2, 1'b1)
    run = 1'b0;
    cyc(100);
    `CHK(st_q, 2'b00)
    ce = 1'b0;
    for (k = 0; k < 200 && st_q !== 2'b10; k++) cyc(1);
    if (k == 200) miscompares++;
    `CHK(trim_q, 8'h00)
    `CHK(cfg_q, 14'h0000)
    `CHK(st_q.low_supply_flag, 1'b0)
    ce = 1'b1;
    run = 1'b1;
    cyc(100);
    `CHK(st_q, 2'b10)
    wr_status(2'b11);
    `CHK(st_q, 2'b10)
    wr_status(2'b00);
    `CHK(st_q, 2'b00)
    wr_trim(8'h57);
    `CHK(trim_q, 8'h57)
    // reset in mid-run: power-up marker again, then one full untrimmed second
    b21 = 1'b1;
    reset_in = 1'b1;
    cyc(3);
    reset_in = 1'b0;
    cyc(2);
    `CHK(st_q, 2'b10)
    `CHK(trim_q, 8'h00)
    wr_status('0);
    for (k = 0; k < 70000 && sec !== 1'b1; k++) cyc(1);
    if (k == 70000) miscompares++;
    // the pulse rides on the closing tick, so one rise fewer is seen
    `CHK(rises, OSC_HZ - 1)
    cyc(1);
    `CHK(samp, 1'b1)
    cyc(1);
    `CHK(st_q, 2'b01)
    `CHK(cond, 2'h1)
    cyc(1);
    `CHK(samp, 1'b0)
    wr_status('0);
    `CHK(st_q, 2'b00)
    give_verdict();
  end
endmodule : rtc_trim_and_halt_monitor_test
